// ---- hdl/rism_pkg.sv ----
// constants, register map and types for the remote io status map
package rism_pkg;
  localparam int DW        = 16;
  localparam int AW        = 8;
  localparam int NUM_CH    = 8;
  localparam int NUM_SLV   = 16;
  localparam int AWORDS    = 16;
  localparam int AIDX_W    = 5;
  localparam int CH_W      = 3;
  localparam int ERR_W     = 8;
  localparam int SAMPLE_W  = 32;
  localparam int ASYNC_W   = NUM_CH * SAMPLE_W + NUM_SLV + ERR_W + NUM_SLV;

  // host word addresses
  localparam logic [AW-1:0] ADDR_SLV_STAT  = 8'h00;
  localparam logic [AW-1:0] ADDR_MST_STAT  = 8'h01;
  localparam logic [AW-1:0] ADDR_DIS_REQ   = 8'h08;
  localparam logic [AW-1:0] ADDR_WIDE_CFG  = 8'h10;
  localparam logic [AW-1:0] ADDR_MAN_CFG   = 8'h11;
  localparam logic [AW-1:0] ADDR_MAN_RST   = 8'h12;
  localparam logic [AW-1:0] ADDR_CTRL      = 8'h13;
  localparam logic [AW-1:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [AW-1:0] ADDR_IRQ_MASK  = 8'h15;
  localparam logic [AW-1:0] ADDR_PEND      = 8'h16;
  localparam logic [AW-1:0] ADDR_AIN_BASE  = 8'h40;
  localparam logic [AW-1:0] ADDR_AOUT_BASE = 8'h60;

  // field positions
  localparam int MST_ERR_LSB  = 0;
  localparam int MST_ACK_BIT  = 8;
  localparam int MST_PEND_BIT = 9;
  localparam int CTRL_CLR_BIT = 0;
  localparam int IRQ_ACK      = 0;
  localparam int IRQ_HOTSWAP  = 1;
  localparam int IRQ_ERR      = 2;
  localparam int IRQ_CYCLE    = 3;
  localparam int IRQ_W        = 4;

  // reset values
  localparam logic [DW-1:0]     RST_WORD = 16'h0000;
  localparam logic [NUM_CH-1:0] RST_WIDE = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 4'h0;

  // timing: one scan step of the update engine
  localparam int CLK_MHZ      = 250;
  localparam int UPD_STEP_NS  = 64;
  localparam int UPD_STEP_CYC = (UPD_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_W        = 5;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_LO   = 2'b01,
    SCAN_HI   = 2'b11,
    SCAN_DONE = 2'b10
  } rism_scan_t;
endpackage : rism_pkg

// ---- hdl/rism_scan_engine.sv ----
// update engine: walks analog channels one word per step
`timescale 1ns/100ps
module rism_scan_engine
  import rism_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  rism_upd_if.engine upd
);
  rism_scan_t        state_q;
  rism_scan_t        state_d;
  logic [DIV_W-1:0]  div_q;
  logic [CH_W-1:0]   ch_q;
  logic [CH_W-1:0]   ch_d;
  logic [NUM_CH-1:0] wide_q;
  logic              tick_w;
  logic              last_w;
  logic [AIDX_W-1:0] base_w [0:NUM_CH];

  assign tick_w = (div_q == DIV_W'(UPD_STEP_CYC - 1));
  assign last_w = (ch_q == CH_W'(NUM_CH - 1));

  // word offsets packed back to back, two per wide channel
  assign base_w[0] = '0;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_base
    assign base_w[i+1] = base_w[i] + (wide_q[i] ? 5'h02 : 5'h01);
  end

  assign upd.wide_act   = wide_q;
  assign upd.ch         = ch_q;
  assign upd.hi         = (state_q == SCAN_HI);
  assign upd.xfer       = tick_w && (state_q == SCAN_LO ||
                                     state_q == SCAN_HI);
  assign upd.waddr      = base_w[ch_q] + {4'h0, upd.hi};
  assign upd.cycle_done = tick_w && (state_q == SCAN_DONE);

  always_comb begin
    state_d = state_q;
    ch_d    = ch_q;
    case (state_q)
      SCAN_IDLE: begin
        state_d = SCAN_LO;
        ch_d    = '0;
      end
      SCAN_LO: begin
        if (wide_q[ch_q]) begin
          state_d = SCAN_HI;
        end else if (last_w) begin
          state_d = SCAN_DONE;
        end else begin
          ch_d = ch_q + 3'h1;
        end
      end
      SCAN_HI: begin
        if (last_w) begin
          state_d = SCAN_DONE;
        end else begin
          state_d = SCAN_LO;
          ch_d    = ch_q + 3'h1;
        end
      end
      SCAN_DONE: state_d = SCAN_IDLE;
      default:   state_d = SCAN_IDLE;
    endcase
  end

  // the engine steps far slower than host accesses
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_q <= '0;
    end else begin
      div_q <= tick_w ? '0 : div_q + 5'h01;
    end
  end

  // layout frozen per cycle so a host edit cannot tear the map
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= SCAN_IDLE;
      ch_q    <= '0;
      wide_q  <= RST_WIDE;
    end else if (tick_w) begin
      state_q <= state_d;
      ch_q    <= ch_d;
      if (state_q == SCAN_IDLE) begin
        wide_q <= upd.wide;
      end
    end
  end

  // helper for the checks below: last word offset written
  logic [AIDX_W-1:0] last_addr_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_addr_q <= '0;
    end else if (upd.xfer) begin
      last_addr_q <= upd.waddr;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_chan_consecutive: assert property (
    upd.xfer && !upd.hi && ch_q != 3'h0 |-> upd.waddr == last_addr_q + 5'h01)
    else $error("analog channel word not consecutive");
  a_wide_pair: assert property (
    upd.xfer && upd.hi |-> wide_q[ch_q] && upd.waddr == last_addr_q + 5'h01)
    else $error("second word of wide channel misplaced");
  a_step_slow: assert property (
    upd.xfer |=> !upd.xfer [*8])
    else $error("update steps too close together");
  c_wide_hi: cover property (upd.xfer && upd.hi);
  c_cycle_done: cover property (upd.cycle_done);
endmodule : rism_scan_engine

// ---- hdl/rism_status_map.sv ----
// remote io status map: shared host memory, status and slave control
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module rism_status_map
  import rism_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [AW-1:0]              addr_in,
  input  wire logic [DW-1:0]              wr_data_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [DW-1:0]              rd_data_out,
  input  wire logic [NUM_CH*SAMPLE_W-1:0] ain_data_in,
  input  wire logic [NUM_SLV-1:0]         slave_ok_in,
  input  wire logic [ERR_W-1:0]           err_code_in,
  input  wire logic [NUM_SLV-1:0]         hotswap_in,
  output logic      [NUM_CH*SAMPLE_W-1:0] aout_data_out,
  output logic      [NUM_SLV-1:0]         slave_disable_out,
  output logic      [NUM_SLV-1:0]         rescan_out,
  output logic                            irq_out
);
  rism_upd_if upd ();

  rism_scan_engine u_engine (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .upd      (upd.engine)
  );

  // pin synchronisers, all slow-side inputs in one bus
  logic [ASYNC_W-1:0]          async_s1_q;
  logic [ASYNC_W-1:0]          async_s2_q;
  logic [NUM_CH*SAMPLE_W-1:0]  ain_s_w;
  logic [NUM_SLV-1:0]          ok_s_w;
  logic [ERR_W-1:0]            err_s_w;
  logic [NUM_SLV-1:0]          hs_s_w;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      async_s1_q <= '0;
      async_s2_q <= '0;
    end else begin
      async_s1_q <= {ain_data_in, slave_ok_in, err_code_in, hotswap_in};
      async_s2_q <= async_s1_q;
    end
  end
  assign {ain_s_w, ok_s_w, err_s_w, hs_s_w} = async_s2_q;

  // registers
  logic [DW-1:0]      ain_mem  [0:AWORDS-1];
  logic [DW-1:0]      aout_mem [0:AWORDS-1];
  logic [NUM_SLV-1:0] slv_stat_q;
  logic [ERR_W-1:0]   err_q;
  logic [NUM_SLV-1:0] dis_req_q;
  logic               ack_q;
  logic               ack_d;
  logic [NUM_CH-1:0]  wide_q;
  logic [NUM_SLV-1:0] man_cfg_q;
  logic [NUM_SLV-1:0] pend_q;
  logic [NUM_SLV-1:0] pend_d;
  logic [NUM_SLV-1:0] hs_prev_q;
  logic [IRQ_W-1:0]   irq_q;
  logic [IRQ_W-1:0]   irq_d;
  logic [IRQ_W-1:0]   irq_mask_q;
  logic [IRQ_W-1:0]   irq_mask_d;
  logic [IRQ_W-1:0]   irq_set_w;
  logic [DW-1:0]      rd_data_q;
  logic [NUM_CH*SAMPLE_W-1:0] aout_q;
  logic [NUM_SLV-1:0] disable_q;
  logic [NUM_SLV-1:0] rescan_q;
  logic [NUM_SLV-1:0] rescan_d;
  logic               irq_out_q;

  // decode
  logic              in_ain_w;
  logic              in_aout_w;
  logic [3:0]        midx_w;
  logic [3:0]        widx_w;
  logic              wr_dis_w;
  logic              wr_wide_w;
  logic              wr_man_w;
  logic              wr_mrst_w;
  logic              wr_clr_w;
  logic              wr_mask_w;
  logic              rd_irq_w;
  logic [DW-1:0]     mst_word_w;
  logic [DW-1:0]     rd_mux_w;
  logic [NUM_SLV-1:0] hs_rise_w;
  logic [NUM_SLV-1:0] man_rst_w;
  logic [DW-1:0]     sample_w;

  assign in_ain_w  = addr_in[AW-1:4] == ADDR_AIN_BASE[AW-1:4];
  assign in_aout_w = addr_in[AW-1:4] == ADDR_AOUT_BASE[AW-1:4];
  assign midx_w    = addr_in[3:0];
  assign widx_w    = upd.waddr[3:0];
  assign wr_dis_w  = wr_in && addr_in == ADDR_DIS_REQ;
  assign wr_wide_w = wr_in && addr_in == ADDR_WIDE_CFG;
  assign wr_man_w  = wr_in && addr_in == ADDR_MAN_CFG;
  assign wr_mrst_w = wr_in && addr_in == ADDR_MAN_RST;
  assign wr_clr_w  = wr_in && addr_in == ADDR_CTRL &&
                     wr_data_in[CTRL_CLR_BIT];
  assign wr_mask_w = wr_in && addr_in == ADDR_IRQ_MASK;
  assign rd_irq_w  = rd_in && addr_in == ADDR_IRQ_STAT;
  assign man_rst_w = wr_mrst_w ? wr_data_in : '0;

  // error code low, flags high
  assign mst_word_w = {6'h00, |pend_q, ack_q, err_q};

  assign rd_mux_w =
    in_ain_w                   ? ain_mem[midx_w]          :
    in_aout_w                  ? aout_mem[midx_w]         :
    addr_in == ADDR_SLV_STAT   ? slv_stat_q               :
    addr_in == ADDR_MST_STAT   ? mst_word_w               :
    addr_in == ADDR_DIS_REQ    ? dis_req_q                :
    addr_in == ADDR_WIDE_CFG   ? {8'h00, wide_q}          :
    addr_in == ADDR_MAN_CFG    ? man_cfg_q                :
    addr_in == ADDR_IRQ_STAT   ? {12'h000, irq_q}         :
    addr_in == ADDR_IRQ_MASK   ? {12'h000, irq_mask_q}    :
    addr_in == ADDR_PEND       ? pend_q                   :
                                 RST_WORD;

  // host read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_q <= RST_WORD;
    end else begin
      rd_data_q <= rd_in ? rd_mux_w : RST_WORD;
    end
  end

  // analog words: engine fills inputs, host fills outputs
  assign sample_w = ain_s_w[{upd.ch, upd.hi, 4'h0} +: DW];
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < AWORDS; i++) begin
        ain_mem[i] <= RST_WORD;
      end
    end else if (upd.xfer) begin
      ain_mem[widx_w] <= sample_w;
    end
  end

  // output words must already be binary; no conversion here
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < AWORDS; i++) begin
        aout_mem[i] <= RST_WORD;
      end
    end else if (wr_in && in_aout_w) begin
      aout_mem[midx_w] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aout_q <= '0;
    end else if (upd.xfer) begin
      aout_q[{upd.ch, upd.hi, 4'h0} +: DW] <= aout_mem[widx_w];
      if (!upd.hi && !upd.wide_act[upd.ch]) begin
        aout_q[{upd.ch, 1'b1, 4'h0} +: DW] <= RST_WORD;
      end
    end
  end

  // status words refresh once per update cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      slv_stat_q <= '0;
      err_q      <= '0;
    end else if (upd.cycle_done) begin
      slv_stat_q <= ok_s_w;
      err_q      <= err_s_w;
    end
  end

  // disable handshake: a new request drops the ack until
  // the next cycle end applies it to every slave at once
  assign ack_d = wr_dis_w        ? 1'b0       :
                 upd.cycle_done  ? |dis_req_q : ack_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dis_req_q <= '0;
      ack_q     <= 1'b0;
      disable_q <= '0;
    end else begin
      ack_q <= ack_d;
      if (wr_dis_w) begin
        dis_req_q <= wr_data_in;
      end
      if (upd.cycle_done) begin
        disable_q <= dis_req_q;
      end
    end
  end

  // configuration, cleared as a whole by the clear command
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wide_q    <= RST_WIDE;
      man_cfg_q <= '0;
    end else if (wr_clr_w) begin
      wide_q    <= RST_WIDE;
      man_cfg_q <= '0;
    end else begin
      if (wr_wide_w) begin
        wide_q <= wr_data_in[NUM_CH-1:0];
      end
      if (wr_man_w) begin
        man_cfg_q <= wr_data_in;
      end
    end
  end
  assign upd.wide = wide_q;

  // hot swap: automatic rescan, or hold until host resets it
  assign hs_rise_w = hs_s_w & ~hs_prev_q;
  assign pend_d    = wr_clr_w ? '0 :
                     (pend_q & ~man_rst_w) | (hs_rise_w & man_cfg_q);
  assign rescan_d  = (hs_rise_w & ~man_cfg_q) | (man_rst_w & pend_q);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hs_prev_q <= '0;
      pend_q    <= '0;
      rescan_q  <= '0;
    end else begin
      hs_prev_q <= hs_s_w;
      pend_q    <= pend_d;
      rescan_q  <= rescan_d;
    end
  end

  // interrupts: sticky, read clears, a same-cycle set survives
  assign irq_set_w[IRQ_ACK]     = ack_d & ~ack_q;
  assign irq_set_w[IRQ_HOTSWAP] = |hs_rise_w;
  assign irq_set_w[IRQ_ERR]     = upd.cycle_done && err_s_w != err_q &&
                                  err_s_w != 8'h00;
  assign irq_set_w[IRQ_CYCLE]   = upd.cycle_done;
  assign irq_d      = (irq_q & ~{IRQ_W{rd_irq_w}}) | irq_set_w;
  assign irq_mask_d = wr_mask_w ? wr_data_in[IRQ_W-1:0] : irq_mask_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_q      <= RST_IRQ;
      irq_mask_q <= RST_IRQ;
      irq_out_q  <= 1'b0;
    end else begin
      irq_q      <= irq_d;
      irq_mask_q <= irq_mask_d;
      irq_out_q  <= |(irq_d & irq_mask_d);
    end
  end

  assign rd_data_out       = rd_data_q;
  assign aout_data_out     = aout_q;
  assign slave_disable_out = disable_q;
  assign rescan_out        = rescan_q;
  assign irq_out           = irq_out_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_stat_read: assert property (
    rd_in && addr_in == ADDR_SLV_STAT |=> rd_data_out == $past(slv_stat_q))
    else $error("slave status word read wrong");
  a_dis_write: assert property (
    wr_dis_w |=> dis_req_q == $past(wr_data_in))
    else $error("disable request word not stored");
  a_mst_layout: assert property (
    rd_in && addr_in == ADDR_MST_STAT |=>
      rd_data_out[7:0] == $past(err_q) &&
      rd_data_out[MST_ACK_BIT] == $past(ack_q))
    else $error("master status word layout wrong");
  a_ack_applied: assert property (
    ack_q |-> dis_req_q != 16'h0000 && slave_disable_out == dis_req_q)
    else $error("ack without applied disable");
  a_ack_shared: assert property (
    upd.cycle_done && !wr_dis_w && dis_req_q != 16'h0000 |=> ack_q)
    else $error("shared ack missing after cycle");
  a_auto_rescan: assert property (
    |(hs_rise_w & ~man_cfg_q) |=>
      (rescan_out & $past(hs_rise_w & ~man_cfg_q)) ==
      $past(hs_rise_w & ~man_cfg_q))
    else $error("automatic rescan missing");
  a_manual_hold: assert property (
    |(hs_rise_w & man_cfg_q) && !wr_clr_w |=> |pend_q)
    else $error("manual slave not held pending");
  a_clear_cfg: assert property (
    wr_clr_w |=> wide_q == RST_WIDE && man_cfg_q == 16'h0000 &&
                 pend_q == 16'h0000)
    else $error("configuration not erased");
  a_ain_copy: assert property (
    upd.xfer |=> ain_mem[$past(widx_w)] == $past(sample_w))
    else $error("analog input word not moved");
  a_irq_level: assert property (
    irq_out == |(irq_q & irq_mask_q))
    else $error("interrupt level wrong");
  c_ack_seen: cover property (ack_q && slave_disable_out != 16'h0000);
  c_manual_rescan: cover property (|(man_rst_w & pend_q));
  c_irq_clear: cover property (rd_irq_w && irq_q != RST_IRQ);
endmodule : rism_status_map

// ---- hdl/rism_upd_if.sv ----
// link between the scan engine and the shared memory
`timescale 1ns/100ps
interface rism_upd_if;
  import rism_pkg::*;
  logic [NUM_CH-1:0] wide;
  logic [NUM_CH-1:0] wide_act;
  logic              xfer;
  logic              hi;
  logic [CH_W-1:0]   ch;
  logic [AIDX_W-1:0] waddr;
  logic              cycle_done;
  modport engine (input wide, output wide_act, xfer, hi, ch, waddr,
                  cycle_done);
  modport mem    (output wide, input wide_act, xfer, hi, ch, waddr,
                  cycle_done);
endinterface : rism_upd_if

// ---- verification/rism_slave_model.sv ----
// remote slave side model: drives the field inputs of the status map
`timescale 1ns/100ps
module rism_slave_model
  import rism_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic [NUM_CH*SAMPLE_W-1:0] set_ain_in,
  input  wire logic [NUM_SLV-1:0]         set_ok_in,
  input  wire logic [ERR_W-1:0]           set_err_in,
  input  wire logic [NUM_SLV-1:0]         set_swap_in,
  input  wire logic [NUM_SLV-1:0]         rescan_in,
  output logic      [NUM_CH*SAMPLE_W-1:0] ain_out,
  output logic      [NUM_SLV-1:0]         ok_out,
  output logic      [ERR_W-1:0]           err_out,
  output logic      [NUM_SLV-1:0]         swap_out,
  output logic      [31:0]                rescans_out
);
  initial begin
    ain_out     = '0;
    ok_out      = '0;
    err_out     = '0;
    swap_out    = '0;
    rescans_out = '0;
  end

  // field values change on their own schedule, not tied to host scans
  always @(posedge clk_in) begin
    ain_out  <= set_ain_in;
    ok_out   <= set_ok_in;
    err_out  <= set_err_in;
    swap_out <= set_swap_in;
    if (|rescan_in) begin
      rescans_out <= rescans_out + 32'h0000_0001;
    end
  end
endmodule : rism_slave_model

// ---- verification/rism_status_map_tb_top.sv ----
// self-checking testbench of the remote io status map
`timescale 1ns/100ps
module rism_status_map_tb_top;
  import rism_pkg::*;
  logic                       clk_in;
  logic                       rst_n_in;
  logic [AW-1:0]              addr_in;
  logic [DW-1:0]              wr_data_in;
  logic                       wr_in;
  logic                       rd_in;
  logic [DW-1:0]              rd_data_out;
  logic [NUM_CH*SAMPLE_W-1:0] ain_data_in;
  logic [NUM_SLV-1:0]         slave_ok_in;
  logic [ERR_W-1:0]           err_code_in;
  logic [NUM_SLV-1:0]         hotswap_in;
  logic [NUM_CH*SAMPLE_W-1:0] aout_data_out;
  logic [NUM_SLV-1:0]         slave_disable_out;
  logic [NUM_SLV-1:0]         rescan_out;
  logic                       irq_out;
  logic [NUM_CH*SAMPLE_W-1:0] set_ain;
  logic [NUM_SLV-1:0]         set_ok;
  logic [ERR_W-1:0]           set_err;
  logic [NUM_SLV-1:0]         set_swap;
  logic [31:0]                rescans;
  int                         num_errors;
  int                         num_checks;

  rism_status_map dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .ain_data_in(ain_data_in),
    .slave_ok_in(slave_ok_in), .err_code_in(err_code_in),
    .hotswap_in(hotswap_in), .aout_data_out(aout_data_out),
    .slave_disable_out(slave_disable_out), .rescan_out(rescan_out),
    .irq_out(irq_out));

  rism_slave_model slaves (.clk_in(clk_in), .set_ain_in(set_ain),
    .set_ok_in(set_ok), .set_err_in(set_err), .set_swap_in(set_swap),
    .rescan_in(rescan_out), .ain_out(ain_data_in), .ok_out(slave_ok_in),
    .err_out(err_code_in), .swap_out(hotswap_in), .rescans_out(rescans));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask : bus_rd

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] m,
                        input logic [DW-1:0] e);
    logic [DW-1:0] d;
    bus_rd(a, d);
    check(32'(d & m), 32'(e));
  endtask : rd_chk

  // bounded poll: the update cycle is far slower than a host read
  task automatic poll(input logic [AW-1:0] a, input logic [DW-1:0] m,
                      input logic [DW-1:0] e);
    logic [DW-1:0] d;
    int            n;
    n = 0;
    bus_rd(a, d);
    while (((d & m) !== e) && n < 400) begin
      bus_rd(a, d);
      n++;
    end
    check(32'(d & m), 32'(e));
  endtask : poll

  // three done events guarantee one whole cycle after the last write
  task automatic wait_cycle;
    repeat (3) poll(ADDR_IRQ_STAT, 16'h0008, 16'h0008);
  endtask : wait_cycle

  task automatic count_hi(input int idx, input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      #1 if (rescan_out[idx] === 1'b1) n++;
      @(posedge clk_in);
    end
  endtask : count_hi

  task automatic t_reset;
    rd_chk(ADDR_SLV_STAT, 16'hFFFF, 16'h0000);
    rd_chk(ADDR_MST_STAT, 16'hFFFF, 16'h0000);
    rd_chk(ADDR_DIS_REQ, 16'hFFFF, 16'h0000);
    rd_chk(8'h30, 16'hFFFF, 16'h0000);
    @(posedge clk_in);
    #1 check(32'(rd_data_out), 32'h0000_0000);
    check(32'(irq_out), 32'h0000_0000);
  endtask : t_reset

  task automatic t_status;
    @(posedge clk_in);
    set_ok  <= 16'hA55A;
    set_err <= 8'h3C;
    poll(ADDR_SLV_STAT, 16'hFFFF, 16'hA55A);
    poll(ADDR_MST_STAT, 16'h00FF, 16'h003C);
    rd_chk(ADDR_IRQ_STAT, 16'h0004, 16'h0004);
    bus_wr(ADDR_MST_STAT, 16'hFFFF);
    rd_chk(ADDR_MST_STAT, 16'hFCFF, 16'h003C);
  endtask : t_status

  task automatic t_analog;
    @(posedge clk_in);
    for (int c = 0; c < NUM_CH; c++) begin
      set_ain[c*32 +: 32] <= {16'hB000 + 16'(c), 16'hA000 + 16'(c)};
    end
    for (int c = 0; c < NUM_CH; c++) begin
      bus_wr(ADDR_AOUT_BASE + 8'(c), 16'h1230 + 16'(c));
    end
    wait_cycle();
    for (int c = 0; c < NUM_CH; c++) begin
      rd_chk(ADDR_AIN_BASE + 8'(c), 16'hFFFF, 16'hA000 + 16'(c));
      check(aout_data_out[c*32 +: 32], 32'(16'h1230 + 16'(c)));
    end
  endtask : t_analog

  task automatic t_wide;
    bus_wr(ADDR_WIDE_CFG, 16'h0001);
    bus_wr(ADDR_AOUT_BASE, 16'h1111);
    bus_wr(ADDR_AOUT_BASE + 8'h01, 16'h2222);
    bus_wr(ADDR_AOUT_BASE + 8'h02, 16'h3333);
    wait_cycle();
    rd_chk(ADDR_WIDE_CFG, 16'hFFFF, 16'h0001);
    rd_chk(ADDR_AIN_BASE, 16'hFFFF, 16'hA000);
    rd_chk(ADDR_AIN_BASE + 8'h01, 16'hFFFF, 16'hB000);
    rd_chk(ADDR_AIN_BASE + 8'h02, 16'hFFFF, 16'hA001);
    check(aout_data_out[31:0], 32'h2222_1111);
    check(aout_data_out[63:32], 32'h0000_3333);
  endtask : t_wide

  task automatic t_disable;
    // both first and last slave in one write, as one ack covers all
    bus_wr(ADDR_DIS_REQ, 16'h8001);
    rd_chk(ADDR_MST_STAT, 16'h0100, 16'h0000);
    check(32'(slave_disable_out), 32'h0000_0000);
    poll(ADDR_MST_STAT, 16'h0100, 16'h0100);
    check(32'(slave_disable_out), 32'h0000_8001);
    rd_chk(ADDR_IRQ_STAT, 16'h0001, 16'h0001);
    rd_chk(ADDR_DIS_REQ, 16'hFFFF, 16'h8001);
    bus_wr(ADDR_DIS_REQ, 16'h0000);
    rd_chk(ADDR_MST_STAT, 16'h0100, 16'h0000);
    wait_cycle();
    check(32'(slave_disable_out), 32'h0000_0000);
    rd_chk(ADDR_MST_STAT, 16'h0100, 16'h0000);
  endtask : t_disable

  task automatic t_swap;
    int n;
    @(posedge clk_in);
    set_swap[2] <= 1'b1;
    count_hi(2, 8, n);
    check(32'(n), 32'h0000_0001);
    bus_wr(ADDR_MAN_CFG, 16'h0020);
    set_swap[5] <= 1'b1;
    count_hi(5, 10, n);
    check(32'(n), 32'h0000_0000);
    rd_chk(ADDR_PEND, 16'hFFFF, 16'h0020);
    rd_chk(ADDR_MST_STAT, 16'h0200, 16'h0200);
    bus_wr(ADDR_MAN_RST, 16'h0020);
    count_hi(5, 4, n);
    check(32'(n), 32'h0000_0001);
    check(rescans, 32'h0000_0002);
    rd_chk(ADDR_PEND, 16'hFFFF, 16'h0000);
  endtask : t_swap

  task automatic t_clear;
    bus_wr(ADDR_WIDE_CFG, 16'h0003);
    bus_wr(ADDR_CTRL, 16'h0001);
    rd_chk(ADDR_WIDE_CFG, 16'hFFFF, 16'h0000);
    rd_chk(ADDR_MAN_CFG, 16'hFFFF, 16'h0000);
    rd_chk(ADDR_PEND, 16'hFFFF, 16'h0000);
  endtask : t_clear

  task automatic t_irq;
    int n;
    bus_wr(ADDR_IRQ_MASK, 16'h0008);
    n = 0;
    while (irq_out !== 1'b1 && n < 400) begin
      @(posedge clk_in) #1;
      n++;
    end
    check(32'(irq_out), 32'h0000_0001);
    rd_chk(ADDR_IRQ_STAT, 16'h0008, 16'h0008);
    bus_wr(ADDR_IRQ_MASK, 16'h0000);
    rd_chk(ADDR_IRQ_MASK, 16'hFFFF, 16'h0000);
    repeat (200) @(posedge clk_in);
    #1 check(32'(irq_out), 32'h0000_0000);
  endtask : t_irq

  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_n_in   = 1'b0;
    addr_in    = '0;
    wr_data_in = '0;
    wr_in      = 1'b0;
    rd_in      = 1'b0;
    set_ain    = '0;
    set_ok     = '0;
    set_err    = '0;
    set_swap   = '0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_status();
    t_analog();
    t_wide();
    t_disable();
    t_swap();
    t_clear();
    t_irq();
    end_sim();
  end

  // whole run is a few thousand cycles; this cuts a hang short
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : rism_status_map_tb_top
